// >>> pkg/pwr_mode_pkg.sv
// Constants, types and reset values for the accelerometer power mode control
// Summary of operation
// - Enable pin low: shut every block down and ignore all serial bus traffic.
// - Enable high, standby set: only power-on reset and digital logic, analog off.
// - Standby answers the bus, all registers read/write; host configures here.
// - Enable high, standby clear, boot done: every block on, bus still reachable.
// - Active to standby keeps every register value unchanged.
// - Standby to active resets a designated register subset; others keep values.
// - Self-test applies a test force; axis offset scales with full-scale range.
// - Self-test output is real acceleration plus test force, not force alone.
// - Results from base offset 0x00 are two's complement, zero g mid-range.
// - After enable rises, boot with trim load completes within the boot time.
// - After standby to active, first valid data after three ODR periods.
package pwr_mode_pkg;

  localparam int          DATA_W        = 12;
  localparam int          AXES          = 3;
  localparam logic [7:0]  OUT_BASE_ADDR = 8'h00;

  // Clock period and boot time (1.55 ms) in ns; longest time rounds down
  localparam int          CLK_PERIOD_NS = 4;
  localparam int          BOOT_TIME_NS  = 1_550_000;
  localparam int          BOOT_CYCLES   = BOOT_TIME_NS / CLK_PERIOD_NS;
  localparam int          BOOT_CNT_W    = 19;

  localparam logic [1:0]  TURN_ON_ODR_PERIODS = 2'h3;

  localparam logic [1:0]  FS_NONE = 2'h0;
  localparam logic [1:0]  FS_2G   = 2'h1;
  localparam logic [1:0]  FS_4G   = 2'h2;
  localparam logic [1:0]  FS_8G   = 2'h3;

  // Self-test shift at 2g range, counts: X -195, Y -195, Z +945
  localparam logic signed [DATA_W:0] ST_OFS_X = 13'h1f3d;
  localparam logic signed [DATA_W:0] ST_OFS_Y = 13'h1f3d;
  localparam logic signed [DATA_W:0] ST_OFS_Z = 13'h03b1;

  typedef enum logic [1:0] {
    MODE_SHUTDOWN = 2'b00,
    MODE_BOOT     = 2'b01,
    MODE_STANDBY  = 2'b10,
    MODE_ACTIVE   = 2'b11
  } mode_t;

  typedef logic [AXES-1:0][DATA_W-1:0] axes_t;

  typedef struct packed {
    mode_t                 mode;
    logic [BOOT_CNT_W-1:0] boot_cnt;
    logic [1:0]            odr_cnt;
    logic                  subset_clr;
  } ctrl_state_t;

  localparam ctrl_state_t CTRL_RST = '{mode: MODE_SHUTDOWN, boot_cnt: 19'h00000,
                                       odr_cnt: 2'h0, subset_clr: 1'b0};

  typedef struct packed {
    axes_t data;
    logic  vld;
  } fmt_state_t;

  localparam fmt_state_t FMT_RST = '{data: 36'h000000000, vld: 1'b0};

endpackage

// >>> pkg/sample_path_if.sv
// Interface carrying samples between the mode controller and the formatter
`timescale 1ns/100ps
interface sample_path_if;
  logic                 sample_vld;
  pwr_mode_pkg::axes_t  accel;
  logic                 self_test;
  logic [1:0]           fs_sel;
  logic                 data_clr;
  pwr_mode_pkg::axes_t  out_data;
  logic                 out_vld;

  modport ctrl (output sample_vld, output accel, output self_test, output fs_sel,
                output data_clr, input out_data, input out_vld);
  modport fmt  (input sample_vld, input accel, input self_test, input fs_sel,
                input data_clr, output out_data, output out_vld);
endinterface

// >>> rtl/accel_out_format.sv
// Output formatter: self-test sum, saturation, two's complement result hold
`timescale 1ns/100ps
module accel_out_format (
  input  wire logic       i_core_clk,
  input  wire logic       i_arst_n,
  sample_path_if.fmt      sp
);

  pwr_mode_pkg::fmt_state_t st_r;
  pwr_mode_pkg::fmt_state_t st_nxt;
  // Net, since each axis drives its own slice from the generate loop
  wire pwr_mode_pkg::axes_t axis_nxt;
  logic [1:0]               st_shift;

  // Sensitivity halves per range step, so the test force in counts does too
  always_comb begin
    case (sp.fs_sel)
      pwr_mode_pkg::FS_4G: st_shift = 2'h1;
      pwr_mode_pkg::FS_8G: st_shift = 2'h2;
      default:             st_shift = 2'h0;
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < pwr_mode_pkg::AXES; g++) begin : g_axis
      logic signed [pwr_mode_pkg::DATA_W:0] ofs;
      logic signed [pwr_mode_pkg::DATA_W:0] sum;
      assign ofs = (g == 0) ? pwr_mode_pkg::ST_OFS_X :
                   (g == 1) ? pwr_mode_pkg::ST_OFS_Y : pwr_mode_pkg::ST_OFS_Z;
      // Real signal plus test force, never the force alone
      assign sum = $signed({sp.accel[g][pwr_mode_pkg::DATA_W-1], sp.accel[g]})
                 + (sp.self_test ? (ofs >>> st_shift) : 13'sh0000);
      // Saturate to the 12-bit two's complement range
      assign axis_nxt[g] = (sum[12] != sum[11]) ? {sum[12], {11{~sum[12]}}} : sum[11:0];
    end
  endgenerate

  always_comb begin
    st_nxt     = st_r;
    st_nxt.vld = sp.sample_vld;
    if (sp.data_clr) begin
      st_nxt = pwr_mode_pkg::FMT_RST;
    end else if (sp.sample_vld) begin
      st_nxt.data = axis_nxt;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_r <= pwr_mode_pkg::FMT_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sp.out_data = st_r.data;
  assign sp.out_vld  = st_r.vld;

  property p_plain_pass;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      sp.sample_vld && !sp.self_test && !sp.data_clr |=> sp.out_data == $past(sp.accel);
  endproperty
  a_plain_pass: assert property (p_plain_pass)
    else $error("Sample not passed through unchanged");

  property p_st_sum;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      sp.sample_vld && sp.self_test && !sp.data_clr && sp.fs_sel == pwr_mode_pkg::FS_2G
      && sp.accel[0] == 12'h064 && sp.accel[2] == 12'h000
      |=> sp.out_data[0] == 12'hfa1 && sp.out_data[2] == 12'h3b1 && sp.out_vld;
  endproperty
  a_st_sum: assert property (p_st_sum)
    else $error("Self-test output is not signal plus test force");

  property p_st_scale;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      sp.sample_vld && sp.self_test && !sp.data_clr && sp.fs_sel == pwr_mode_pkg::FS_8G
      && sp.accel[2] == 12'h000 |=> sp.out_data[2] == 12'h0ec;
  endproperty
  a_st_scale: assert property (p_st_scale)
    else $error("Self-test offset not scaled by full-scale range");

endmodule

// >>> rtl/sensor_power_mode_control.sv
// Operating mode control: shutdown, boot, standby, active and sample gating
`timescale 1ns/100ps
module sensor_power_mode_control #(
  parameter int BOOT_CYCLES = pwr_mode_pkg::BOOT_CYCLES
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_en,
  input  wire logic        i_standby,
  input  wire logic        i_self_test,
  input  wire logic [1:0]  i_fs_sel,
  input  wire logic        i_odr_tick,
  input  wire logic        i_sample_vld,
  input  wire logic [11:0] i_accel_x,
  input  wire logic [11:0] i_accel_y,
  input  wire logic [11:0] i_accel_z,
  output logic             o_por_en,
  output logic             o_digital_en,
  output logic             o_analog_en,
  output logic             o_bus_listen,
  output logic             o_trim_load,
  output logic             o_boot_done,
  output logic             o_reg_clear,
  output logic             o_subset_clr,
  output logic             o_st_drive,
  output logic [11:0]      o_accel_x,
  output logic [11:0]      o_accel_y,
  output logic [11:0]      o_accel_z,
  output logic             o_data_vld
);

  localparam logic [pwr_mode_pkg::BOOT_CNT_W-1:0] BOOT_LAST =
    pwr_mode_pkg::BOOT_CNT_W'(BOOT_CYCLES - 1);

  pwr_mode_pkg::ctrl_state_t st_r;
  pwr_mode_pkg::ctrl_state_t st_nxt;
  logic                      boot_done;
  logic                      active_on;
  logic                      data_ok;
  logic                      go_active;

  sample_path_if sp ();

  assign boot_done = (st_r.mode == pwr_mode_pkg::MODE_STANDBY) ||
                     (st_r.mode == pwr_mode_pkg::MODE_ACTIVE);
  assign data_ok   = (st_r.odr_cnt == pwr_mode_pkg::TURN_ON_ODR_PERIODS);
  assign go_active = (st_r.mode == pwr_mode_pkg::MODE_STANDBY) && i_en && !i_standby;

  // Enables come straight from the pin and bit, so they follow in the same cycle
  assign o_por_en     = i_en;
  assign o_digital_en = i_en;
  assign active_on    = i_en && !i_standby && boot_done;
  assign o_analog_en  = active_on;
  // Bus stays deaf through boot; the register file is not yet trimmed
  assign o_bus_listen = i_en && boot_done;
  assign o_trim_load  = i_en && (st_r.mode == pwr_mode_pkg::MODE_BOOT);
  assign o_boot_done  = boot_done;
  // Shutdown loses all digital state; standby never clears anything
  assign o_reg_clear  = !i_en || (st_r.mode == pwr_mode_pkg::MODE_SHUTDOWN);
  assign o_subset_clr = st_r.subset_clr;
  assign o_st_drive   = i_self_test && active_on;

  always_comb begin
    st_nxt            = st_r;
    st_nxt.subset_clr = 1'b0;
    if (!i_en) begin
      st_nxt = pwr_mode_pkg::CTRL_RST;
    end else begin
      case (st_r.mode)
        pwr_mode_pkg::MODE_SHUTDOWN: begin
          st_nxt.mode     = pwr_mode_pkg::MODE_BOOT;
          st_nxt.boot_cnt = '0;
        end
        pwr_mode_pkg::MODE_BOOT: begin
          if (st_r.boot_cnt == BOOT_LAST) begin
            st_nxt.mode    = i_standby ? pwr_mode_pkg::MODE_STANDBY
                                       : pwr_mode_pkg::MODE_ACTIVE;
            st_nxt.odr_cnt = 2'h0;
          end else begin
            st_nxt.boot_cnt = st_r.boot_cnt + 1'b1;
          end
        end
        pwr_mode_pkg::MODE_STANDBY: begin
          if (!i_standby) begin
            st_nxt.mode       = pwr_mode_pkg::MODE_ACTIVE;
            st_nxt.subset_clr = 1'b1;
            st_nxt.odr_cnt    = 2'h0;
          end
        end
        pwr_mode_pkg::MODE_ACTIVE: begin
          if (i_standby) begin
            // Nothing is cleared on the way down; registers hold as they are
            st_nxt.mode = pwr_mode_pkg::MODE_STANDBY;
          end else if (i_odr_tick && !data_ok) begin
            st_nxt.odr_cnt = st_r.odr_cnt + 1'b1;
          end
        end
        default: begin
          st_nxt = pwr_mode_pkg::CTRL_RST;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_r <= pwr_mode_pkg::CTRL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Samples pass only once the analog path has settled
  assign sp.sample_vld = i_sample_vld && active_on &&
                         (st_r.mode == pwr_mode_pkg::MODE_ACTIVE) && data_ok;
  assign sp.accel      = {i_accel_z, i_accel_y, i_accel_x};
  assign sp.self_test  = i_self_test;
  assign sp.fs_sel     = i_fs_sel;
  assign sp.data_clr   = o_reg_clear;

  accel_out_format u_fmt (
    .i_core_clk (i_core_clk),
    .i_arst_n   (i_arst_n),
    .sp         (sp.fmt)
  );

  assign o_accel_x  = sp.out_data[0];
  assign o_accel_y  = sp.out_data[1];
  assign o_accel_z  = sp.out_data[2];
  assign o_data_vld = sp.out_vld;

  logic [pwr_mode_pkg::BOOT_CNT_W-1:0] boot_cnt;
  logic [1:0]                          odr_cnt;
  assign boot_cnt = st_r.boot_cnt;
  assign odr_cnt  = st_r.odr_cnt;

  property p_shutdown_deaf;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      !i_en |-> !o_bus_listen && !o_analog_en && !o_st_drive && o_reg_clear
      ##1 st_r.mode == pwr_mode_pkg::MODE_SHUTDOWN;
  endproperty
  a_shutdown_deaf: assert property (p_shutdown_deaf)
    else $error("Block still alive with enable low");

  property p_standby_analog_off;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      i_en && i_standby |-> !o_analog_en && o_digital_en && o_por_en;
  endproperty
  a_standby_analog_off: assert property (p_standby_analog_off)
    else $error("Analog path on in standby");

  property p_standby_bus;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      i_en && st_r.mode == pwr_mode_pkg::MODE_STANDBY |-> o_bus_listen && !o_reg_clear;
  endproperty
  a_standby_bus: assert property (p_standby_bus)
    else $error("Bus not served in standby");

  property p_active_all_on;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      i_en && !i_standby && st_r.mode == pwr_mode_pkg::MODE_ACTIVE
      |-> o_analog_en && o_digital_en && o_por_en && o_bus_listen;
  endproperty
  a_active_all_on: assert property (p_active_all_on)
    else $error("Block missing in active mode");

  property p_keep_on_standby;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      i_en && i_standby && st_r.mode == pwr_mode_pkg::MODE_ACTIVE
      |=> !o_subset_clr && st_r.mode == pwr_mode_pkg::MODE_STANDBY && $stable(o_accel_x)
          && $stable(o_accel_z);
  endproperty
  a_keep_on_standby: assert property (p_keep_on_standby)
    else $error("State disturbed on active to standby");

  property p_subset_pulse;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      go_active |=> o_subset_clr && o_reg_clear == !i_en ##1 !o_subset_clr;
  endproperty
  a_subset_pulse: assert property (p_subset_pulse)
    else $error("Subset reset not a single pulse on standby to active");

  property p_subset_only_wake;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      o_subset_clr |-> $past(st_r.mode) == pwr_mode_pkg::MODE_STANDBY;
  endproperty
  a_subset_only_wake: assert property (p_subset_only_wake)
    else $error("Subset reset outside standby to active");

  property p_boot_time;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      $rose(boot_done) |-> $past(boot_cnt) == BOOT_LAST && o_bus_listen == i_en;
  endproperty
  a_boot_time: assert property (p_boot_time)
    else $error("Boot ended at the wrong count");

  property p_turn_on;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      go_active |=> !sp.sample_vld [*3];
  endproperty
  a_turn_on: assert property (p_turn_on)
    else $error("Sample taken too soon after wake");

  property p_valid_after_ticks;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      sp.sample_vld |-> odr_cnt == pwr_mode_pkg::TURN_ON_ODR_PERIODS ##1 o_data_vld;
  endproperty
  a_valid_after_ticks: assert property (p_valid_after_ticks)
    else $error("Valid data before three ODR periods");

  property p_same_cycle;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      $rose(i_standby) && st_r.mode == pwr_mode_pkg::MODE_ACTIVE
      |-> !o_analog_en ##1 (!o_analog_en || !i_standby);
  endproperty
  a_same_cycle: assert property (p_same_cycle)
    else $error("Analog enable lagged the standby bit");

endmodule

// >>> sim/sensor_front_model.sv
// Behavioural analog front end: output rate ticks and conversions
`timescale 1ns/100ps
module sensor_front_model #(
  parameter int ODR_DIV = 6
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_analog_en,
  input  wire logic [11:0] i_x,
  input  wire logic [11:0] i_y,
  input  wire logic [11:0] i_z,
  output logic             o_odr_tick,
  output logic             o_sample_vld,
  output logic [11:0]      o_accel_x,
  output logic [11:0]      o_accel_y,
  output logic [11:0]      o_accel_z
);
  logic [7:0] cnt_r;

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_r        <= 8'h00;
      o_odr_tick   <= 1'h0;
      o_sample_vld <= 1'h0;
    end else begin
      o_odr_tick   <= 1'h0;
      o_sample_vld <= o_odr_tick;
      if (!i_analog_en) begin
        cnt_r <= 8'h00;
      end else if (cnt_r == 8'(ODR_DIV - 1)) begin
        cnt_r      <= 8'h00;
        o_odr_tick <= 1'h1;
      end else begin
        cnt_r <= cnt_r + 8'h01;
      end
    end
  end

  // Lines carry garbage between conversions, never the last value
  assign o_accel_x = o_sample_vld ? i_x : ~i_x;
  assign o_accel_y = o_sample_vld ? i_y : ~i_y;
  assign o_accel_z = o_sample_vld ? i_z : ~i_z;
endmodule

// >>> sim/sensor_power_mode_control_tb.sv
// Self-checking bench for the power mode control block
`timescale 1ns/100ps
module sensor_power_mode_control_tb;
  localparam int BOOT = 8;
  typedef struct {
    logic st; logic [1:0] fs; logic [11:0] x, y, z, ex, ey, ez;
  } row_t;
  logic        clk, rst_n, en, stby, st, odr, svld, aen, vld, sclr;
  logic        por, dig, bus, trim, bdone, rclr, std;
  logic [1:0]  fs;
  logic [11:0] ax, ay, az, sx, sy, sz, ox, oy, oz;
  int          bad_count, comparisons, cyc, ticks;
  row_t rows[6] = '{
    '{1'h0, 2'h1, 12'h064, 12'hf9c, 12'h400, 12'h064, 12'hf9c, 12'h400},
    '{1'h1, 2'h1, 12'h064, 12'h000, 12'h000, 12'hfa1, 12'hf3d, 12'h3b1},
    '{1'h1, 2'h2, 12'h000, 12'h000, 12'h000, 12'hf9e, 12'hf9e, 12'h1d8},
    '{1'h1, 2'h3, 12'h000, 12'h000, 12'h000, 12'hfcf, 12'hfcf, 12'h0ec},
    '{1'h1, 2'h0, 12'h000, 12'h000, 12'h000, 12'hf3d, 12'hf3d, 12'h3b1},
    '{1'h1, 2'h1, 12'h800, 12'h000, 12'h7ff, 12'h800, 12'hf3d, 12'h7ff}};

  sensor_power_mode_control #(.BOOT_CYCLES(BOOT)) i_sensor_power_mode_control (
    .i_core_clk(clk), .i_arst_n(rst_n), .i_en(en), .i_standby(stby), .i_self_test(st),
    .i_fs_sel(fs), .i_odr_tick(odr), .i_sample_vld(svld), .i_accel_x(ax), .i_accel_y(ay),
    .i_accel_z(az), .o_por_en(por), .o_digital_en(dig), .o_analog_en(aen),
    .o_bus_listen(bus), .o_trim_load(trim), .o_boot_done(bdone), .o_reg_clear(rclr),
    .o_subset_clr(sclr), .o_st_drive(std), .o_accel_x(ox), .o_accel_y(oy),
    .o_accel_z(oz), .o_data_vld(vld));

  sensor_front_model i_sensor_front_model (
    .i_core_clk(clk), .i_arst_n(rst_n), .i_analog_en(aen), .i_x(sx), .i_y(sy), .i_z(sz),
    .o_odr_tick(odr), .o_sample_vld(svld), .o_accel_x(ax), .o_accel_y(ay),
    .o_accel_z(az));

  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  task automatic final_report;
    $display("Comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk1(input string n, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk12(input string n, input logic [11:0] e, input logic [11:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  // Bounded wait, ends on the falling edge where the result pulse stands
  task automatic wait_vld;
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (vld !== 1'h1 && n < 200);
    if (n >= 200) chk1("data_vld", 1'h1, 1'h0);
  endtask

  always @(posedge clk) begin
    cyc++;
    if (odr === 1'h1) ticks <= ticks + 1;
    // Whole sequence needs well under a thousand cycles
    if (cyc == 5000) begin
      bad_count++;
      final_report();
    end
  end

  initial begin
    en = 1'h0; stby = 1'h1; st = 1'h0; fs = 2'h1;
    sx = 12'h000; sy = 12'h000; sz = 12'h000;
    bad_count = 0; comparisons = 0; cyc = 0; ticks = 0;
    rst_n = 1'h0;
    repeat (20) @(negedge clk);
    rst_n = 1'h1;
    @(negedge clk);
    chk1("bus_listen", 1'h0, bus);
    chk1("reg_clear", 1'h1, rclr);
    chk1("analog_en", 1'h0, aen);
    chk1("por_en", 1'h0, por);
    en = 1'h1;
    #1 chk1("digital_en", 1'h1, dig);
    @(negedge clk);
    chk1("trim_load", 1'h1, trim);
    chk1("bus_listen", 1'h0, bus);
    repeat (BOOT - 2) @(negedge clk);
    chk1("boot_done", 1'h0, bdone);
    repeat (3) @(negedge clk);
    chk1("boot_done", 1'h1, bdone);
    chk1("bus_listen", 1'h1, bus);
    chk1("analog_en", 1'h0, aen);
    chk1("por_en", 1'h1, por);
    chk1("trim_load", 1'h0, trim);
    repeat (20) @(negedge clk);
    chk1("data_vld", 1'h0, vld);
    stby = 1'h0;
    ticks = 0;
    #1 chk1("analog_en", 1'h1, aen);
    @(negedge clk);
    chk1("subset_clr", 1'h1, sclr);
    chk1("bus_listen", 1'h1, bus);
    @(negedge clk);
    chk1("subset_clr", 1'h0, sclr);
    wait_vld();
    chk1("odr_periods", 1'h1, ticks >= 3);
    foreach (rows[i]) begin
      stby = 1'h1;
      @(negedge clk);
      // Host reconfigures only from standby
      st = rows[i].st; fs = rows[i].fs;
      sx = rows[i].x; sy = rows[i].y; sz = rows[i].z;
      stby = 1'h0;
      wait_vld();
      wait_vld();
      chk1("st_drive", rows[i].st, std);
      chk12("accel_x", rows[i].ex, ox);
      chk12("accel_y", rows[i].ey, oy);
      chk12("accel_z", rows[i].ez, oz);
    end
    stby = 1'h1;
    #1 chk1("analog_en", 1'h0, aen);
    chk1("st_drive", 1'h0, std);
    repeat (30) @(negedge clk);
    chk1("subset_clr", 1'h0, sclr);
    chk12("accel_x", 12'h800, ox);
    chk12("accel_z", 12'h7ff, oz);
    chk1("bus_listen", 1'h1, bus);
    stby = 1'h0;
    @(negedge clk);
    chk1("subset_clr", 1'h1, sclr);
    chk12("accel_y", 12'hf3d, oy);
    en = 1'h0;
    #1 chk1("bus_listen", 1'h0, bus);
    chk1("analog_en", 1'h0, aen);
    chk1("reg_clear", 1'h1, rclr);
    repeat (2) @(negedge clk);
    chk12("accel_x", 12'h000, ox);
    chk1("boot_done", 1'h0, bdone);
    // Reset mid-boot, then boot straight into active
    en = 1'h1;
    stby = 1'h0;
    repeat (3) @(negedge clk);
    rst_n = 1'h0;
    #1 chk1("trim_load", 1'h0, trim);
    chk1("reg_clear", 1'h1, rclr);
    repeat (2) @(negedge clk);
    rst_n = 1'h1;
    @(negedge clk);
    chk1("trim_load", 1'h1, trim);
    chk1("analog_en", 1'h0, aen);
    repeat (BOOT) @(negedge clk);
    chk1("analog_en", 1'h1, aen);
    chk1("subset_clr", 1'h0, sclr);
    final_report();
  end
endmodule
